// >>> vtc_consts.vh
// Operation
// RULE1 - select 0: line blanking high over whole blanking, EAV and SAV included.
// RULE2 - select 1: line blanking follows the H bit of received TRS words.
// RULE3 - select is one bit of proc_disable_reg, written only over the host port.
// RULE4 - carrier detect low: second serial input treated as valid.
// RULE5 - carrier detect high: input invalid, lock forced low, parallel outputs muted; code mutes data only, blanking flags keep running.
// RULE6 - loop-through enable low: both loop-through outputs high impedance.
// RULE7 - loop-through enable high: true and complement loop-through outputs driven.
// RULE8 - host mode: words shifted in on shared pin, captured on host serial clock.
// RULE9 - test select high: shared pin routed to boundary-scan TDI, not host input.
// RULE10 - outside party holds shared serial pin high when host port unused.
// RULE11 - field blanking high through vertical blanking, following received V bit.
// RULE12 - field blanking low on every line outside vertical blanking.
// RULE13 - blanking flags update synchronously with the pixel clock.
// RULE14 - outside party drives test select to pick scan or host mode.
// RULE15 - carrier detect and loop enable pass synchronizers before use.
`ifndef VTC_CONSTS_VH
`define VTC_CONSTS_VH

// ----------------------------------------------------------------
// trs words and xyz field positions
// ----------------------------------------------------------------
`define VTC_TRS_W0 10'h3ff
`define VTC_TRS_W1 10'h000
`define VTC_XYZ_F_BIT 8
`define VTC_XYZ_V_BIT 7
`define VTC_XYZ_H_BIT 6
`define VTC_TRS_TAIL 3'h4
`define VTC_MUTE_WORD 10'h000

// ----------------------------------------------------------------
// host port map
// ----------------------------------------------------------------
`define VTC_PROC_DISABLE_ADDR 16'h0000
`define VTC_H_CONFIG_BIT 0
`define VTC_PROC_DISABLE_RST 16'h0000
`define VTC_HOST_BITS 5'h10

`endif

// >>> vtc_sync.v
`timescale 1ns/1ps
`default_nettype none
module vtc_sync #(
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // level in and out
  input wire async_i,
  output reg sync_o
);

  reg meta;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire

// >>> vtc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "vtc_consts.vh"
module vtc_top #(
  parameter DW = 10,
  parameter HW = 16
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // received video words
  input wire [DW-1:0] video_data_i,
  input wire lock_raw_i,
  // carrier detect from equalizer
  input wire carrier_detect_in2_i,
  // loop-through
  input wire loopthru_out_enable_i,
  input wire loop_data_i,
  // shared serial control pins
  input wire test_host_sel_i,
  input wire host_sclk_i,
  input wire host_cs_n_i,
  input wire shared_serial_in_pin_i,
  // parallel video out
  output reg [DW-1:0] video_data_o,
  output reg line_blank_o,
  output reg field_blank_o,
  output reg lock_indicator_o,
  // loop-through outputs
  output reg loopthru_serial_out_o,
  output reg loopthru_serial_out_n_o,
  output reg loopthru_serial_out_oe_o,
  // scan and host
  output reg scan_tdi_o,
  output reg [HW-1:0] proc_disable_reg_o
);

  // ----------------------------------------------------------------
  // synchronizers
  // ----------------------------------------------------------------
  wire cd_sync;
  wire loop_en_sync;

  vtc_sync #(.RST_VAL(1'b1)) u_cd_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(carrier_detect_in2_i),
    .sync_o(cd_sync)
  ); // see RULE15

  vtc_sync #(.RST_VAL(1'b0)) u_en_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(loopthru_out_enable_i),
    .sync_o(loop_en_sync)
  ); // see RULE15

  // ----------------------------------------------------------------
  // trs detection pipeline
  // ----------------------------------------------------------------
  reg [DW-1:0] d0;
  reg [DW-1:0] d1;
  reg [DW-1:0] d2;
  reg [DW-1:0] d3;
  reg blank_full;
  reg [2:0] sav_tail;
  reg h_trs;
  reg v_trs;
  wire h_config;
  wire trs_hit;
  wire xyz_h;
  wire xyz_v;
  wire trs_eav;
  wire trs_sav;
  reg next_blank_full;
  reg [2:0] next_sav_tail;
  reg next_line_blank;

  function is_word;
    input [DW-1:0] w;
    input [DW-1:0] ref_w;
    begin
      is_word = (w == ref_w);
    end
  endfunction

  // d3 is the oldest word; d0 then holds the xyz word
  assign trs_hit = is_word(d3, `VTC_TRS_W0) && is_word(d2, `VTC_TRS_W1) &&
                   is_word(d1, `VTC_TRS_W1);
  assign xyz_h = d0[`VTC_XYZ_H_BIT];
  assign xyz_v = d0[`VTC_XYZ_V_BIT];
  assign trs_eav = trs_hit && xyz_h;
  assign trs_sav = trs_hit && !xyz_h;
  assign h_config = proc_disable_reg_o[`VTC_H_CONFIG_BIT];

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      d0 <= {DW{1'b0}};
      d1 <= {DW{1'b0}};
      d2 <= {DW{1'b0}};
      d3 <= {DW{1'b0}};
    end else begin
      d0 <= video_data_i;
      d1 <= d0;
      d2 <= d1;
      d3 <= d2;
    end
  end

  // ----------------------------------------------------------------
  // blanking flag generation
  // ----------------------------------------------------------------
  always @* begin
    next_blank_full = blank_full;
    next_sav_tail = sav_tail;
    if (trs_eav) begin
      // eav: blank from its first word onward
      next_blank_full = 1'b1; // see RULE1
      next_sav_tail = 3'h0;
    end else if (trs_sav) begin
      // sav: hold blanking through all four sav words
      next_blank_full = 1'b1; // see RULE1
      next_sav_tail = `VTC_TRS_TAIL;
    end else if (sav_tail != 3'h0) begin
      next_sav_tail = sav_tail - 3'h1;
      // drops on the word after the sav xyz word
      if (sav_tail == 3'h1) begin
        next_blank_full = 1'b0; // see RULE1
      end
    end
    if (h_config) begin
      next_line_blank = trs_hit ? xyz_h : h_trs; // see RULE2
    end else begin
      next_line_blank = next_blank_full; // see RULE1
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blank_full <= 1'b1;
      sav_tail <= 3'h0;
      h_trs <= 1'b1;
      v_trs <= 1'b1;
      line_blank_o <= 1'b1;
      field_blank_o <= 1'b1;
    end else begin
      blank_full <= next_blank_full;
      sav_tail <= next_sav_tail;
      if (trs_hit) begin
        h_trs <= xyz_h; // see RULE2
        v_trs <= xyz_v; // see RULE11
      end
      line_blank_o <= next_line_blank; // see RULE13
      field_blank_o <= trs_hit ? xyz_v : v_trs; // see RULE11, see RULE12, see RULE13
    end
  end

  // ----------------------------------------------------------------
  // carrier gating of lock and parallel data
  // ----------------------------------------------------------------
  // only data and lock are muted; blanking flags keep running
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      video_data_o <= `VTC_MUTE_WORD;
      lock_indicator_o <= 1'b0;
    end else if (cd_sync) begin
      video_data_o <= `VTC_MUTE_WORD; // see RULE5
      lock_indicator_o <= 1'b0; // see RULE5
    end else begin
      video_data_o <= d3; // see RULE4
      lock_indicator_o <= lock_raw_i; // see RULE4
    end
  end

  // ----------------------------------------------------------------
  // loop-through driver
  // ----------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      loopthru_serial_out_o <= 1'b0;
      loopthru_serial_out_n_o <= 1'b1;
      loopthru_serial_out_oe_o <= 1'b0;
    end else begin
      loopthru_serial_out_o <= loop_data_i;
      loopthru_serial_out_n_o <= ~loop_data_i;
      loopthru_serial_out_oe_o <= loop_en_sync; // see RULE6, see RULE7
    end
  end

  // ----------------------------------------------------------------
  // shared serial pin: scan tdi or host input
  // ----------------------------------------------------------------
  localparam ST_ADDR = 3'b001;
  localparam ST_DATA = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg sclk_q;
  reg [HW-1:0] shreg;
  reg [HW-1:0] addr;
  reg [4:0] bitcnt;
  wire host_mode;
  wire sclk_rise;
  wire word_done;
  wire [HW-1:0] shifted;
  wire take_bit;

  function frame_idle;
    input cs_n;
    input scan_sel;
    begin
      frame_idle = cs_n || scan_sel;
    end
  endfunction

  assign host_mode = ~test_host_sel_i;
  assign sclk_rise = host_sclk_i & ~sclk_q;
  assign shifted = {shreg[HW-2:0], shared_serial_in_pin_i};
  assign word_done = host_mode && !host_cs_n_i && sclk_rise &&
                     (bitcnt == (`VTC_HOST_BITS - 5'h1));
  // one bit per rising host clock while a frame is open, until both words are in
  assign take_bit = sclk_rise && !frame_idle(host_cs_n_i, test_host_sel_i) &&
                    (state != ST_DONE);

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scan_tdi_o <= 1'b1;
    end else begin
      // tdi is forced high outside scan mode, whatever the pin carries
      scan_tdi_o <= test_host_sel_i ? shared_serial_in_pin_i : 1'b1; // see RULE9
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_ADDR: begin
        if (word_done) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (word_done) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_ADDR;
      end
    endcase
    // chip select high or scan mode restarts the framing
    if (frame_idle(host_cs_n_i, test_host_sel_i)) begin
      next_state = ST_ADDR;
    end
  end

  // framing: state, clock history and bit count
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_ADDR;
      sclk_q <= 1'b1;
      bitcnt <= 5'h0;
    end else begin
      state <= next_state;
      sclk_q <= host_sclk_i;
      if (frame_idle(host_cs_n_i, test_host_sel_i)) begin
        bitcnt <= 5'h0;
      end else if (take_bit) begin
        bitcnt <= word_done ? 5'h0 : bitcnt + 5'h1;
      end
    end
  end

  // capture on rising host serial clock
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shreg <= {HW{1'b0}};
      addr <= {HW{1'b0}};
    end else if (take_bit) begin
      shreg <= shifted; // see RULE8
      if (word_done && state == ST_ADDR) begin
        addr <= shifted; // see RULE8
      end
    end
  end

  // register write once a full data word has arrived
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      proc_disable_reg_o <= `VTC_PROC_DISABLE_RST;
    end else if (take_bit && word_done && state == ST_DATA) begin
      if (addr == `VTC_PROC_DISABLE_ADDR) begin
        proc_disable_reg_o <= shifted; // see RULE3
      end
    end
  end

endmodule
`default_nettype wire

// >>> vtc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vtc_checker (
  // clock, reset and inputs
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic lock_raw_i,
  input wire logic carrier_detect_in2_i,
  input wire logic loopthru_out_enable_i,
  input wire logic loop_data_i,
  input wire logic test_host_sel_i,
  input wire logic shared_serial_in_pin_i,
  // outputs
  input wire logic [9:0] video_data_o,
  input wire logic line_blank_o,
  input wire logic field_blank_o,
  input wire logic lock_indicator_o,
  input wire logic loopthru_serial_out_o,
  input wire logic loopthru_serial_out_n_o,
  input wire logic loopthru_serial_out_oe_o,
  input wire logic scan_tdi_o,
  input wire logic [15:0] proc_disable_reg_o
);
  wire cd = carrier_detect_in2_i;
  wire h = proc_disable_reg_o[0];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------
  // trs header seen on the output bus
  // ------------------------------------------
  // muted zeros never end a header: an xyz word has bit 9 set
  sequence s_trs;
    video_data_o == 10'h3ff ##1 video_data_o == 10'h000 ##1 video_data_o == 10'h000
      ##1 video_data_o[9];
  endsequence
  chk_lock_mute: assert property (
    cd [*3] |=> !lock_indicator_o && video_data_o == 10'h000)
    else $error("output not muted");
  chk_lock_pass: assert property (
    (!cd) [*4] |=> lock_indicator_o == $past(lock_raw_i))
    else $error("lock not following");
  chk_oe_off: assert property (
    (!loopthru_out_enable_i) [*4] |=> !loopthru_serial_out_oe_o)
    else $error("loop output not disabled");
  chk_oe_on: assert property (
    loopthru_out_enable_i [*4] |=> loopthru_serial_out_oe_o)
    else $error("loop output not enabled");
  chk_loop_pair: assert property (
    !$past(rst_i) |-> loopthru_serial_out_o == $past(loop_data_i)
      && loopthru_serial_out_n_o == !loopthru_serial_out_o)
    else $error("loop pair wrong");
  chk_tdi_scan: assert property (
    $past(test_host_sel_i) && !$past(rst_i) |-> scan_tdi_o == $past(shared_serial_in_pin_i))
    else $error("tdi wrong");
  chk_field_v: assert property (
    s_trs |-> field_blank_o == video_data_o[7])
    else $error("field flag wrong");
  chk_line_trs: assert property (
    s_trs ##0 (h && $past(h, 3)) |-> line_blank_o == video_data_o[6])
    else $error("line flag wrong");
  chk_line_act: assert property (
    s_trs ##0 (!h && !$past(h, 3) && !video_data_o[6]) |-> line_blank_o ##1 !line_blank_o)
    else $error("line flag wrong");
endmodule
`default_nettype wire

// >>> vtc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module vtc_src_model (
  // clock and field control
  input wire logic core_clk_i,
  input wire logic v_i,
  // word stream
  output logic [9:0] word_o
);
  logic [3:0] pos = 4'h0;
  initial word_o = 10'h040;
  // ------------------------------------------
  // 16-word line: eav, blanking, sav, active
  // ------------------------------------------
  always @(negedge core_clk_i) begin
    pos <= pos + 4'h1;
    if (pos[2])
      word_o <= pos[3] ? 10'h200 : 10'h040;
    else if (pos[1:0] == 2'h0)
      word_o <= 10'h3ff;
    else if (pos[1:0] == 2'h3)
      word_o <= {2'h2, v_i, !pos[3], 4'h0, 2'h3};
    else
      word_o <= 10'h000;
  end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] video_data_i;
  logic lock_raw_i = 1'b1;
  logic carrier_detect_in2_i = 1'b0;
  logic loopthru_out_enable_i = 1'b0;
  logic loop_data_i = 1'b0;
  logic test_host_sel_i = 1'b0;
  logic host_sclk_i = 1'b0;
  logic host_cs_n_i = 1'b1;
  logic shared_serial_in_pin_i = 1'b1;
  logic v_i = 1'b0;
  wire [9:0] video_data_o;
  wire [15:0] proc_disable_reg_o;
  wire line_blank_o, field_blank_o, lock_indicator_o, scan_tdi_o;
  wire loopthru_serial_out_o, loopthru_serial_out_n_o, loopthru_serial_out_oe_o;
  wire [2:0] loop_pins = {loopthru_serial_out_oe_o, loopthru_serial_out_o, loopthru_serial_out_n_o};
  int failures = 0;
  int comparisons = 0;
  vtc_top i_vtc_top (.*);
  vtc_src_model i_vtc_src_model (.core_clk_i, .v_i, .word_o(video_data_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] s, input string n);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] w);
    host_cs_n_i = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      shared_serial_in_pin_i = w[i];
      tick(1);
      host_sclk_i = 1'b1;
      tick(1);
      host_sclk_i = 1'b0;
    end
    tick(1);
    host_cs_n_i = 1'b1;
    shared_serial_in_pin_i = 1'b1;
  endtask
  task automatic hcount(input logic [15:0] e);
    int k;
    k = 0;
    repeat (16) begin
      tick(1);
      k += int'(line_blank_o === 1'b1);
    end
    chk(e, k[15:0], "line blank count");
  endtask
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    summarize();
  end
  initial begin
    tick(3);
    rst_i = 1'b0;
    tick(1);
    chk(16'h1, 16'(scan_tdi_o), "tdi idle");
    chk(16'h0, proc_disable_reg_o, "proc reset");
    tick(40);
    hcount(16'hc);
    wr(32'h0000_0001);
    tick(2);
    chk(16'h1, proc_disable_reg_o, "proc write");
    tick(20);
    hcount(16'h8);
    wr(32'h0005_0000);
    tick(2);
    chk(16'h1, proc_disable_reg_o, "other addr");
    $display("test blanking done");
    v_i = 1'b1;
    tick(48);
    chk(16'h1, 16'(field_blank_o), "field");
    v_i = 1'b0;
    tick(48);
    chk(16'h0, 16'(field_blank_o), "field");
    $display("test field done");
    carrier_detect_in2_i = 1'b1;
    tick(4);
    chk(16'h0, {5'h0, lock_indicator_o, video_data_o}, "mute");
    carrier_detect_in2_i = 1'b0;
    tick(4);
    chk(16'h1, 16'(lock_indicator_o), "lock");
    lock_raw_i = 1'b0;
    tick(2);
    chk(16'h0, 16'(lock_indicator_o), "lock follows");
    lock_raw_i = 1'b1;
    $display("test carrier done");
    chk(16'h0, 16'(loopthru_serial_out_oe_o), "loop oe");
    loopthru_out_enable_i = 1'b1;
    loop_data_i = 1'b1;
    tick(4);
    chk(16'h6, 16'(loop_pins), "loop");
    loop_data_i = 1'b0;
    tick(2);
    chk(16'h5, 16'(loop_pins), "loop");
    $display("test loop done");
    test_host_sel_i = 1'b1;
    shared_serial_in_pin_i = 1'b0;
    tick(2);
    chk(16'h0, 16'(scan_tdi_o), "tdi");
    wr(32'h0000_0000);
    tick(2);
    chk(16'h1, proc_disable_reg_o, "scan write");
    test_host_sel_i = 1'b0;
    $display("test scan done");
    summarize();
  end
endmodule
bind vtc_top vtc_checker i_vtc_checker (.*);
`default_nettype wire
